// ===== rtl/wss_pkg.sv
// Constants, types and helpers for the wakeup start-up sequencer.
// Assumes a 200 MHz system clock; times are kept in milliseconds.
package wss_pkg;

	localparam int WSS_CLK_PERIOD_PS = 5000;
	localparam int WSS_MS_PS         = 1000000000;
	// Clock cycles in one millisecond tick
	localparam int WSS_MS_CYCLES     = WSS_MS_PS / WSS_CLK_PERIOD_PS;

	localparam int WSS_MS_W = 10;
	localparam int WSS_CAD_W = 8;

	// Stage times in ms after the wake event
	localparam logic [WSS_MS_W-1:0] WSS_REG_ON_MS     = 10'h014; // 20
	localparam logic [WSS_MS_W-1:0] WSS_INIT_START_MS = 10'h017; // 23
	localparam logic [WSS_MS_W-1:0] WSS_COMP_SLOW_MS  = 10'h02f; // 47
	localparam logic [WSS_MS_W-1:0] WSS_COMP_FAST_MS  = 10'h023; // 35
	localparam logic [WSS_MS_W-1:0] WSS_FULL_SLOW_MS  = 10'h061; // 97
	localparam logic [WSS_MS_W-1:0] WSS_FULL_FAST_MS  = 10'h03e; // 62
	localparam logic [WSS_MS_W-1:0] WSS_SWITCH_ON_MS  = 10'h116; // 278

	// Switch decision cadence: period 250 ms, phase 28 ms after wake
	localparam logic [WSS_CAD_W-1:0] WSS_CAD_LAST   = 8'hf9; // 249
	localparam logic [WSS_CAD_W-1:0] WSS_CAD_PREV   = 8'h1b; // 27

	// Register byte offsets
	localparam logic [7:0] WSS_CTRL_OFF  = 8'h00;
	localparam logic [7:0] WSS_ALARM_OFF = 8'h04;
	localparam logic [7:0] WSS_STATE_OFF = 8'h08;
	localparam logic [7:0] WSS_INT_OFF   = 8'h0c;
	localparam logic [7:0] WSS_MASK_OFF  = 8'h10;

	// Control register fields
	localparam int WSS_CTRL_W    = 3;
	localparam int WSS_CTRL_FAST = 0;
	localparam int WSS_CTRL_SW   = 1;
	localparam int WSS_CTRL_REG  = 2;
	localparam int WSS_CTRL_SHDN = 3;

	localparam int WSS_ALARM_W = 4;
	localparam int WSS_INT_W   = 6;

	// Wake pins at rest: load sense low, thermistor high
	localparam logic [1:0] WSS_PIN_IDLE = 2'h1;

	typedef enum logic [2:0] {
		WSS_SHUTDOWN  = 3'h0,
		WSS_WAIT_REG  = 3'h1,
		WSS_WAIT_INIT = 3'h3,
		WSS_WAIT_COMP = 3'h2,
		WSS_WAIT_FULL = 3'h6,
		WSS_NORMAL    = 3'h7
	} wss_state_type;

	// Fixed stage order
	function automatic wss_state_type wss_stage_after(
		input wss_state_type s);
		case (s)
			WSS_SHUTDOWN:  return WSS_WAIT_REG;
			WSS_WAIT_REG:  return WSS_WAIT_INIT;
			WSS_WAIT_INIT: return WSS_WAIT_COMP;
			WSS_WAIT_COMP: return WSS_WAIT_FULL;
			default:       return WSS_NORMAL;
		endcase
	endfunction : wss_stage_after

endpackage : wss_pkg

// ===== rtl/wss_time_if.sv
// Millisecond time base link between sequencer and time base.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface wss_time_if;
	import wss_pkg::*;
	logic                start;
	logic                msTick;
	logic [WSS_MS_W-1:0] msCount;
	modport seq  (output start, input msTick, input msCount);
	modport base (input start, output msTick, output msCount);
endinterface : wss_time_if

// ===== rtl/wss_timebase.sv
// Millisecond tick and elapsed-time counter, restarted by start.
// Assumes a free-running clock; msCount saturates at its maximum.
`timescale 1ns/1ps
module wss_timebase import wss_pkg::*; #(
	parameter int MS_CYCLES = WSS_MS_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	wss_time_if.base tb
);
	localparam int DIV_W = $clog2(MS_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
	localparam logic [WSS_MS_W-1:0] CNT_MAX = '1;

	logic [DIV_W-1:0]    div_reg;
	logic [WSS_MS_W-1:0] count_reg;
	logic                tickNow;

	assign tickNow = (div_reg == DIV_LAST);
	assign tb.msTick = tickNow;
	assign tb.msCount = count_reg;

	// Counts from the wake event on a fixed time base
	always_ff @(posedge clk)
	begin
		if (!nrst || tb.start)
		begin
			div_reg   <= '0; // RULE_10
			count_reg <= '0;
		end
		else
		begin
			div_reg <= tickNow ? '0 : div_reg + 1'b1;
			if (tickNow && count_reg != CNT_MAX)
				count_reg <= count_reg + 1'b1;
		end
	end

endmodule : wss_timebase

// ===== rtl/wss_sequencer.sv
// Wakeup start-up sequencer with APB registers and alarm pin.
// Assumes wake pins are asynchronous and an APB master on clk.
//
// Behaviour
// RULE_01 - Thermistor low or load high wakes device
// RULE_02 - Fixed stage series before normal mode
// RULE_03 - Regulator on at 20 ms if enabled
// RULE_04 - Init-started flag at 23 ms
// RULE_05 - Init-complete and scan at 47/35 ms
// RULE_06 - Full-scan flag at 97/62 ms
// RULE_07 - Switch decision once per 250 ms
// RULE_08 - Switches on at 278 ms when enabled
// RULE_09 - Alarm pin low when selected flag active
// RULE_10 - Stage delays from fixed wake time base
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module wss_sequencer import wss_pkg::*; #(
	parameter int MS_CYCLES = WSS_MS_CYCLES,
	parameter int ADDR_W    = 8
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              secondThermistorPin,
	input  wire logic              loadSensePin,
	output logic                   auxRegulatorOutput,
	output logic                   initStartedFlag,
	output logic                   initCompleteFlag,
	output logic                   conversionScanFlag,
	output logic                   fullScanFlag,
	output logic                   switchOn,
	output logic                   normalMode,
	output logic                   alertOut,
	output logic                   alertOe,
	output logic                   irq
);

	wss_time_if tif ();

	wss_timebase #(
		.MS_CYCLES (MS_CYCLES)
	) u_timebase (
		.clk  (clk),
		.nrst (nrst),
		.tb   (tif.base)
	);

	wss_state_type       state_reg;
	wss_state_type       state_next;
	logic [1:0]          s1_reg;
	logic [1:0]          s2_reg;
	logic [1:0]          s3_reg;
	logic [1:0]          pin_reg;
	logic [WSS_CTRL_W-1:0]  ctrl_reg;
	logic [WSS_ALARM_W-1:0] alarm_reg;
	logic [WSS_INT_W-1:0]   int_reg;
	logic [WSS_INT_W-1:0]   int_next;
	logic [WSS_INT_W-1:0]   mask_reg;
	logic [WSS_CAD_W-1:0]   cad_reg;
	logic                fast_reg;
	logic                reg_reg;
	logic                init_reg;
	logic                comp_reg;
	logic                full_reg;
	logic                sw_reg;
	logic                sw_next;
	logic                alert_reg;
	logic                irq_reg;
	logic [31:0]         prdata_reg;
	logic                slverr_reg;

	logic                wakeLvl;
	logic                wakeStart;
	logic                stageDone;
	logic [WSS_MS_W-1:0] stageTarget;
	logic [WSS_MS_W-1:0] compTime;
	logic [WSS_MS_W-1:0] fullTime;
	logic [WSS_MS_W-1:0] msCount;
	logic                fastNow;
	logic                setup;
	logic                access;
	logic                wrCtrl;
	logic                rdClr;
	logic                shutdownCmd;
	logic                decide;
	logic                regNext;
	logic                initNext;
	logic                compNext;
	logic                fullNext;
	logic [4:0]          flagsNow;
	logic [4:0]          flagsNext;
	logic [WSS_INT_W-1:0] events;
	logic [31:0]         rdMux;
	logic                hit;
	logic                selCtrl;
	logic                selAlarm;
	logic                selInt;
	logic                selMask;

	// Wake pins pass three flops; a level counts once the last two agree
	assign wakeLvl = !pin_reg[0] || pin_reg[1]; // RULE_01

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s1_reg  <= WSS_PIN_IDLE;
			s2_reg  <= WSS_PIN_IDLE;
			s3_reg  <= WSS_PIN_IDLE;
			pin_reg <= WSS_PIN_IDLE;
		end
		else
		begin
			s1_reg  <= {loadSensePin, secondThermistorPin};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			pin_reg <= (s2_reg == s3_reg) ? s3_reg : pin_reg;
		end
	end

	// Stage timing
	assign msCount   = tif.msCount;
	assign wakeStart = (state_reg == WSS_SHUTDOWN) && wakeLvl; // RULE_01
	assign tif.start = wakeStart;
	assign fastNow   = wakeStart ? ctrl_reg[WSS_CTRL_FAST] : fast_reg;
	assign compTime  = fast_reg ? WSS_COMP_FAST_MS : WSS_COMP_SLOW_MS;
	assign fullTime  = fast_reg ? WSS_FULL_FAST_MS : WSS_FULL_SLOW_MS;
	assign stageTarget =
		(state_reg == WSS_WAIT_REG)  ? WSS_REG_ON_MS :
		(state_reg == WSS_WAIT_INIT) ? WSS_INIT_START_MS :
		(state_reg == WSS_WAIT_COMP) ? compTime : fullTime; // RULE_10
	assign stageDone = (msCount >= stageTarget);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			WSS_SHUTDOWN:
				if (wakeLvl)
					state_next = WSS_WAIT_REG;
			WSS_NORMAL:
				if (shutdownCmd)
					state_next = WSS_SHUTDOWN;
			default:
				if (shutdownCmd)
					state_next = WSS_SHUTDOWN;
				else if (stageDone)
					state_next = wss_stage_after(state_reg); // RULE_02
		endcase
	end

	// Flags follow the stage reached
	assign regNext  = ctrl_reg[WSS_CTRL_REG] &&
		(state_next != WSS_SHUTDOWN) &&
		(state_next != WSS_WAIT_REG); // RULE_03
	assign initNext = (state_next == WSS_WAIT_COMP) ||
		(state_next == WSS_WAIT_FULL) ||
		(state_next == WSS_NORMAL); // RULE_04
	assign compNext = (state_next == WSS_WAIT_FULL) ||
		(state_next == WSS_NORMAL); // RULE_05
	assign fullNext = (state_next == WSS_NORMAL); // RULE_06

	// Decision cadence runs from the wake event
	assign decide = tif.msTick && (cad_reg == WSS_CAD_PREV);
	assign sw_next = (state_reg != WSS_NORMAL || shutdownCmd) ? 1'b0 :
		decide ? ctrl_reg[WSS_CTRL_SW] : sw_reg; // RULE_07 RULE_08

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg <= WSS_SHUTDOWN;
			fast_reg  <= 1'b0;
			cad_reg   <= '0;
			reg_reg   <= 1'b0;
			init_reg  <= 1'b0;
			comp_reg  <= 1'b0;
			full_reg  <= 1'b0;
			sw_reg    <= 1'b0;
			alert_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			fast_reg  <= fastNow;
			if (wakeStart)
				cad_reg <= '0;
			else if (tif.msTick)
				cad_reg <= (cad_reg == WSS_CAD_LAST) ? '0 :
					cad_reg + 1'b1; // RULE_07
			reg_reg   <= regNext;
			init_reg  <= initNext;
			comp_reg  <= compNext;
			full_reg  <= fullNext;
			sw_reg    <= sw_next;
			alert_reg <= |(alarm_reg &
				{fullNext, compNext, compNext, initNext}); // RULE_09
		end
	end

	// APB slave: zero wait states, data captured in the setup cycle
	assign setup  = psel && !penable;
	assign access = psel && penable;

	always_comb
	begin
		selCtrl  = 1'b0;
		selAlarm = 1'b0;
		selInt   = 1'b0;
		selMask  = 1'b0;
		hit      = 1'b1;
		rdMux    = '0;
		if (paddr[7:0] == WSS_CTRL_OFF)
		begin
			selCtrl = 1'b1;
			rdMux   = 32'(ctrl_reg);
		end
		else if (paddr[7:0] == WSS_ALARM_OFF)
		begin
			selAlarm = 1'b1;
			rdMux    = 32'(alarm_reg);
		end
		else if (paddr[7:0] == WSS_STATE_OFF)
			rdMux = 32'({msCount, flagsNow, state_reg});
		else if (paddr[7:0] == WSS_INT_OFF)
		begin
			selInt = 1'b1;
			rdMux  = 32'(int_reg);
		end
		else if (paddr[7:0] == WSS_MASK_OFF)
		begin
			selMask = 1'b1;
			rdMux   = 32'(mask_reg);
		end
		else
			hit = 1'b0;
	end

	assign wrCtrl = access && pwrite && selCtrl;
	assign shutdownCmd = wrCtrl && pwdata[WSS_CTRL_SHDN];
	assign rdClr  = access && !pwrite && selInt;

	// Sticky events; a new event wins over the read clear
	// Only bits returned by the read are cleared, so a late event survives
	assign flagsNow  = {sw_reg, full_reg, comp_reg, init_reg, reg_reg};
	assign flagsNext = {sw_next, fullNext, compNext, initNext, regNext};
	assign events    = {flagsNext & ~flagsNow, wakeStart};
	assign int_next  = (rdClr ? int_reg & ~prdata_reg[WSS_INT_W-1:0] :
		int_reg) | events;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctrl_reg   <= '0;
			alarm_reg  <= '0;
			mask_reg   <= '0;
			int_reg    <= '0;
			irq_reg    <= 1'b0;
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end
		else
		begin
			if (wrCtrl)
				ctrl_reg <= pwdata[WSS_CTRL_W-1:0];
			if (access && pwrite && selAlarm)
				alarm_reg <= pwdata[WSS_ALARM_W-1:0];
			if (access && pwrite && selMask)
				mask_reg <= pwdata[WSS_INT_W-1:0];
			int_reg <= int_next;
			irq_reg <= |(int_next & mask_reg);
			if (setup)
			begin
				prdata_reg <= rdMux;
				slverr_reg <= !hit;
			end
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = access;
	assign pslverr = slverr_reg;

	assign auxRegulatorOutput = reg_reg;
	assign initStartedFlag    = init_reg;
	assign initCompleteFlag   = comp_reg;
	assign conversionScanFlag = comp_reg;
	assign fullScanFlag       = full_reg;
	assign switchOn           = sw_reg;
	assign normalMode         = (state_reg == WSS_NORMAL);
	// Open drain: only ever pulls low
	assign alertOut           = 1'b0; // RULE_09
	assign alertOe            = alert_reg;
	assign irq                = irq_reg;

	// Checks
	logic decided_reg;
	always_ff @(posedge clk)
	begin
		if (!nrst || state_reg == WSS_SHUTDOWN)
			decided_reg <= 1'b0;
		else if (decide && state_reg == WSS_NORMAL)
			decided_reg <= 1'b1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_wake;
		wakeStart |=> state_reg == WSS_WAIT_REG && msCount == '0;
	endproperty
	a_wake: assert property (p_wake) // RULE_01
		else $error("wake did not start the sequence");

	property p_order;
		(state_reg != $past(state_reg) && state_reg != WSS_SHUTDOWN)
			|-> state_reg == wss_stage_after($past(state_reg));
	endproperty
	a_order: assert property (p_order) // RULE_02 RULE_10
		else $error("stage order broken");

	property p_reg;
		($rose(auxRegulatorOutput) && $past(state_reg) == WSS_WAIT_REG)
			|-> msCount == WSS_REG_ON_MS;
	endproperty
	a_reg: assert property (p_reg) // RULE_03
		else $error("regulator on at wrong time");

	property p_init;
		$rose(initStartedFlag) |-> msCount == WSS_INIT_START_MS;
	endproperty
	a_init: assert property (p_init) // RULE_04
		else $error("init started at wrong time");

	property p_comp;
		$rose(initCompleteFlag) |-> conversionScanFlag &&
			msCount == (fast_reg ? WSS_COMP_FAST_MS : WSS_COMP_SLOW_MS);
	endproperty
	a_comp: assert property (p_comp) // RULE_05
		else $error("init complete at wrong time");

	property p_full;
		$rose(fullScanFlag) |->
			msCount == (fast_reg ? WSS_FULL_FAST_MS : WSS_FULL_SLOW_MS);
	endproperty
	a_full: assert property (p_full) // RULE_06
		else $error("full scan at wrong time");

	property p_cadence;
		($changed(switchOn) && state_reg == WSS_NORMAL &&
			$past(state_reg) == WSS_NORMAL) |-> $past(decide);
	endproperty
	a_cadence: assert property (p_cadence) // RULE_07
		else $error("switch changed off the decision tick");

	property p_switch;
		($rose(switchOn) && !$past(decided_reg)) |->
			msCount == WSS_SWITCH_ON_MS;
	endproperty
	a_switch: assert property (p_switch) // RULE_08
		else $error("first switch-on not at 278 ms");

	property p_alert;
		(|(alarm_reg & {fullScanFlag, conversionScanFlag,
			initCompleteFlag, initStartedFlag}))
			|-> (alertOe && !alertOut) || $changed(alarm_reg);
	endproperty
	a_alert: assert property (p_alert) // RULE_09
		else $error("alarm pin not pulled low");

	c_full_slow: cover property ($rose(fullScanFlag) && !fast_reg);
	c_full_fast: cover property ($rose(fullScanFlag) && fast_reg);
	c_switch: cover property ($rose(switchOn));
	c_shutdown: cover property (normalMode ##1 !normalMode);

endmodule : wss_sequencer

// ===== sim/wss_wake_model.sv
// Far-side model: wake sources on the two wake pins and the alert line.
// Assumes the bench raises wakeReq just after a rising clock edge.
`timescale 1ns/1ps
module wss_wake_model (
	input  wire logic clk,
	input  wire logic wakeReq,
	input  wire logic useLoad,
	input  wire logic alertOut,
	input  wire logic alertOe,
	output logic      secondThermistorPin,
	output logic      loadSensePin,
	output wire logic alertPin
);
	// Thermistor pulled low or load pulled high; otherwise at rest
	always @(posedge clk)
	begin
		secondThermistorPin <= ~(wakeReq & ~useLoad);
		loadSensePin <= wakeReq & useLoad;
	end
	// Open-drain alert line with a pull-up when nobody drives it
	assign alertPin = alertOe ? alertOut : 1'h1;
endmodule : wss_wake_model

// ===== sim/testbench.sv
// Self-checking bench for the wakeup start-up sequencer.
// Assumes a shortened millisecond (MS_CYCLES = 8) and APB access.
`timescale 1ns/1ps
module testbench;
	import wss_pkg::*;
	localparam int MSC = 8;
	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic        wakeReq = 1'h0;
	logic        useLoad = 1'h0;
	logic [3:0]  sel = 4'h8;
	logic [31:0] rd;
	logic        err;
	logic [31:0] prdata;
	logic        pready, pslverr, therm, load, alertOut, alertOe;
	logic        aux_regulator_output, initS, initC, scan, full, sw, normalMode, irq;
	wire logic   alertPin;
	wire logic [4:0] outs = {sw, full, initC, initS, aux_regulator_output};
	int          bad_count = 0;
	int          check_count = 0;

	always #2.5 clk = ~clk;

	wss_sequencer #(.MS_CYCLES(MSC), .ADDR_W(8)) dut (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.secondThermistorPin(therm), .loadSensePin(load),
		.auxRegulatorOutput(aux_regulator_output), .initStartedFlag(initS),
		.initCompleteFlag(initC), .conversionScanFlag(scan),
		.fullScanFlag(full), .switchOn(sw), .normalMode(normalMode),
		.alertOut(alertOut), .alertOe(alertOe), .irq(irq));

	wss_wake_model model (
		.clk(clk), .wakeReq(wakeReq), .useLoad(useLoad),
		.alertOut(alertOut), .alertOe(alertOe),
		.secondThermistorPin(therm), .loadSensePin(load),
		.alertPin(alertPin));

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (pready !== 1'h1)
		begin
			bad_count++;
			give_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Wait for one start-up output, then check elapsed time and alert
	task wait_step(input int idx, input int ms, input logic [3:0] have);
		int n;
		n = 0;
		while (outs[idx] !== 1'h1 && n < 5000)
		begin
			n++;
			@(posedge clk);
		end
		if (outs[idx] !== 1'h1)
		begin
			bad_count++;
			give_verdict;
		end
		apb(1'h0, WSS_STATE_OFF, 32'h0);
		chk("msCount", {22'h0, rd[17:8]}, 32'(ms));
		chk("scanFlag", scan, idx >= 2);
		chk("compFlag", initC, idx >= 2);
		chk("alertPin", alertPin, ~|(sel & have));
		$display("step %0d at %0d ms done", idx, ms);
	endtask : wait_step

	task run_pass(input logic fast, input logic byLoad, input logic swEn);
		apb(1'h1, WSS_MASK_OFF, 32'h20);
		apb(1'h1, WSS_ALARM_OFF, {28'h0, sel});
		apb(1'h1, WSS_CTRL_OFF, {29'h0, 1'h1, swEn, fast});
		@(posedge clk);
		useLoad <= byLoad;
		wakeReq <= 1'h1;
		wait_step(0, 20, 4'h0);
		wait_step(1, 23, 4'h1);
		wait_step(2, fast ? 35 : 47, 4'h7);
		chk("normalEarly", normalMode, 1'h0);
		wait_step(3, fast ? 62 : 97, 4'hf);
		chk("normalMode", normalMode, 1'h1);
		apb(1'h0, WSS_INT_OFF, 32'h0);
		chk("intStatus", rd, 32'h1f);
		chk("irqMasked", irq, 1'h0);
		wakeReq <= 1'h0;
	endtask : run_pass

	task shut_down;
		apb(1'h1, WSS_CTRL_OFF, 32'h8);
		apb(1'h0, WSS_STATE_OFF, 32'h0);
		chk("stateOff", {24'h0, rd[7:0]}, 32'h0);
		chk("normalOff", normalMode, 1'h0);
	endtask : shut_down

	initial
	begin
		int n;
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'h0, 8'(i * 4), 32'h0);
			chk("resetValue", rd, 32'h0);
		end
		apb(1'h1, 8'h14, 32'hffffffff);
		chk("unmappedWrErr", err, 1'h1);
		apb(1'h0, 8'h14, 32'h0);
		chk("unmappedRdErr", err, 1'h1);
		chk("unmappedRd", rd, 32'h0);
		$display("test registers done");
		run_pass(1'h0, 1'h0, 1'h1);
		wait_step(4, 278, 4'hf);
		chk("irqSwitch", irq, 1'h1);
		apb(1'h0, WSS_INT_OFF, 32'h0);
		chk("intSwitch", rd, 32'h20);
		repeat (2) @(posedge clk);
		chk("irqCleared", irq, 1'h0);
		shut_down;
		$display("test slow wake done");
		sel = 4'h2;
		run_pass(1'h1, 1'h1, 1'h0);
		n = 0;
		rd = 32'h0;
		while (rd[17:8] < 10'h117 && n < 1000)
		begin
			n++;
			apb(1'h0, WSS_STATE_OFF, 32'h0);
		end
		if (!(rd[17:8] >= 10'h117))
		begin
			bad_count++;
			give_verdict;
		end
		chk("switchHeld", sw, 1'h0);
		apb(1'h1, WSS_CTRL_OFF, 32'h3);
		wait_step(4, 528, 4'hf);
		chk("regOff", aux_regulator_output, 1'h0);
		shut_down;
		$display("test fast wake done");
		give_verdict;
	end
endmodule : testbench
